// ===== core/lpw_pkg.sv
// shared constants for the low-power mode and wakeup controller
package lpw_pkg;

  // apb byte addresses, one aligned word each
  localparam logic [7:0] ADDR_POWER_DOWN = 8'h00;
  localparam logic [7:0] ADDR_SYS_CLK    = 8'h04;
  localparam logic [7:0] ADDR_LF_CLK     = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0C;

  // power-down codes written to power_down_select_reg
  localparam logic [2:0] MODE_ACTIVE      = 3'h0;
  localparam logic [2:0] MODE_MEM_RET_OFF = 3'h2;
  localparam logic [2:0] MODE_MEM_RET_ON  = 3'h3;
  localparam logic [2:0] MODE_REG_RET     = 3'h4;
  localparam logic [2:0] MODE_STANDBY     = 3'h7;

  // system_clock_control_reg fields
  localparam logic [7:0] SYS_CLK_RESET  = 8'h00;
  localparam int         BYPASS_BIT     = 7;
  localparam int         XOSC_FIELD_HI  = 5;
  localparam int         XOSC_FIELD_LO  = 4;
  localparam logic [1:0] XOSC_OFF_CODE  = 2'h1;

  // low_freq_clock_control_reg fields
  localparam logic [2:0] LF_SRC_RESET   = 3'h7;
  localparam logic [2:0] LF_SRC_NONE    = 3'h7;
  localparam int         LF_XOSC_RUN_BIT = 3;
  localparam int         LF_READY_BIT   = 6;

  // wakeup source positions and per-mode enable masks
  localparam int         NUM_SRC      = 5;
  localparam int         SRC_PIN      = 0;
  localparam int         SRC_TICK     = 1;
  localparam int         SRC_COMP     = 2;
  localparam int         SRC_RADIO    = 3;
  localparam int         SRC_MISC     = 4;
  localparam logic [4:0] MASK_PIN     = 5'h01;
  localparam logic [4:0] MASK_TIMERS  = 5'h07;
  localparam logic [4:0] MASK_STANDBY = 5'h1B;
  localparam logic [4:0] MASK_NONE    = 5'h00;

  // timing, clock at 25 MHz
  localparam int          CLK_MHZ           = 25;
  localparam int          PIN_STARTUP_NS    = 100_000;
  localparam int          STANDBY_WAKE_NS   = 100;
  localparam logic [15:0] PIN_STARTUP_CYC   =
    16'(PIN_STARTUP_NS * CLK_MHZ / 1000);
  localparam logic [15:0] STANDBY_WAKE_CYC  =
    16'(STANDBY_WAKE_NS * CLK_MHZ / 1000);
  localparam logic [15:0] SHORT_PRESTART_CYC = 16'h0004;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_PRESTART,
    ST_STARTUP,
    ST_WAKE
  } lpw_state_e;

endpackage

// ===== core/lpw_power_manager.sv
// Summary of operation
// - code 100 enters register retention; timers on when slow clock active
// - memory and register retention, timers off, wake only on pin
// - memory retention timers on keeps slow oscillator, rtc, watchdog clocked
// - memory retention timers on wakes on pin, tick or comparator
// - pin wake from memory retention timers on starts within 100 us
// - tick wake pre-starts regulators and fast crystal ahead of time
// - short pre-start in memory retention when crystal start field leaves crystal disabled
// - any wake from memory retention timers on resets the system
// - wake from register retention resumes execution, no reset
// - register retention timers on wakes on pin, tick or comparator
// - short pre-start also when bypass bit kept crystal on in retention
// - no short pre-start if register retention entered before crystal running
// - standby adds radio and misc interrupts, ignores comparator
// - standby stops cpu clock, keeps io, wakes in about 100 ns
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module lpw_power_manager
  import lpw_pkg::*;
#(
  parameter logic [15:0] P_LONG_PRESTART_CYC = 16'h0200
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  input  wire logic        i_pin_wake,
  input  wire logic        i_tick_wake,
  input  wire logic        i_comp_wake,
  input  wire logic        i_radio_irq,
  input  wire logic        i_misc_peripheral_irq,
  input  wire logic        i_fast_crystal_osc_running,
  output var  logic        o_cpu_clk_en,
  output var  logic        o_io_active,
  output var  logic        o_regulator_en,
  output var  logic        o_fast_crystal_osc_en,
  output var  logic        o_fast_rc_osc_en,
  output var  logic        o_slow_osc_en,
  output var  logic        o_timers_clk_en,
  output var  logic        o_sys_reset_req,
  output var  logic        o_resume
);

  localparam int AST_SHORT_BOUND   = 5;
  localparam int AST_STANDBY_BOUND = 3;
  localparam int AST_PIN_BOUND     = int'(PIN_STARTUP_CYC);

  logic               rst_s1_q;
  logic               rst_n;
  logic [NUM_SRC:0]   in_s1_q;
  logic [NUM_SRC:0]   in_s2_q;
  logic [NUM_SRC:0]   raw_in;
  logic [NUM_SRC-1:0] wake_s;
  logic               xosc_run_s;
  logic [NUM_SRC-1:0] en_mask;
  logic [NUM_SRC-1:0] hit;
  lpw_state_e         state_q;
  logic [2:0]         mode_q;
  logic               timers_on_q;
  logic               xosc_at_entry_q;
  logic               short_q;
  logic [15:0]        cnt_q;
  logic [NUM_SRC-1:0] cause_q;
  logic [7:0]         sys_clk_q;
  logic [2:0]         lf_src_q;
  logic               apb_setup;
  logic               apb_acc;
  logic               sleep_wr;
  logic               code_ok;
  logic               short_d;
  logic               lf_active;
  logic               standby_slp;
  logic [15:0]        startup_cnt_q;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  assign raw_in = {i_fast_crystal_osc_running, i_misc_peripheral_irq,
                   i_radio_irq, i_comp_wake, i_tick_wake, i_pin_wake};

  // every asynchronous input gets its own two-flop synchroniser
  for (genvar g = 0; g <= NUM_SRC; g++)
  begin : g_sync
    always_ff @(posedge i_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        in_s1_q[g] <= 1'b0;
        in_s2_q[g] <= 1'b0;
      end
      else
      begin
        in_s1_q[g] <= raw_in[g];
        in_s2_q[g] <= in_s1_q[g];
      end
    end
  end

  assign wake_s     = in_s2_q[NUM_SRC-1:0];
  assign xosc_run_s = in_s2_q[NUM_SRC];
  assign lf_active  = (lf_src_q != LF_SRC_NONE);
  assign standby_slp = (state_q == ST_SLEEP) && (mode_q == MODE_STANDBY);

  // per-mode wakeup enables; sources foreign to the mode never wake it
  always_comb
  begin
    case (mode_q)
      MODE_MEM_RET_OFF: en_mask = MASK_PIN;
      MODE_MEM_RET_ON:  en_mask = MASK_TIMERS;
      MODE_REG_RET:     en_mask = timers_on_q ? MASK_TIMERS : MASK_PIN;
      MODE_STANDBY:     en_mask = MASK_STANDBY;
      default:          en_mask = MASK_NONE;
    endcase
  end

  assign hit = wake_s & en_mask;

  // apb: zero-wait answer in the access phase, registered outputs
  assign apb_setup = i_psel && !i_penable;
  assign apb_acc   = i_psel && i_penable && o_pready;
  assign code_ok   = (i_pwdata[2:0] == MODE_MEM_RET_OFF) ||
                     (i_pwdata[2:0] == MODE_MEM_RET_ON) ||
                     (i_pwdata[2:0] == MODE_REG_RET) ||
                     (i_pwdata[2:0] == MODE_STANDBY);
  // unknown codes are dropped rather than trapping the core asleep
  assign sleep_wr  = apb_acc && i_pwrite && (i_paddr == ADDR_POWER_DOWN) &&
                     code_ok && (state_q == ST_ACTIVE);

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
    else
    begin
      o_pready  <= apb_setup;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (apb_setup)
      begin
        case (i_paddr)
          ADDR_POWER_DOWN: o_prdata[2:0] <= mode_q;
          ADDR_SYS_CLK:    o_prdata[7:0] <= sys_clk_q;
          ADDR_LF_CLK:
          begin
            o_prdata[2:0]            <= lf_src_q;
            o_prdata[LF_XOSC_RUN_BIT] <= xosc_run_s;
            o_prdata[LF_READY_BIT]   <= lf_active;
          end
          ADDR_STATUS:
            o_prdata[9:0] <= {timers_on_q, short_q, cause_q, mode_q};
          default:         o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // clock control registers written by software
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_clk_q <= SYS_CLK_RESET;
      lf_src_q  <= LF_SRC_RESET;
    end
    else if (apb_acc && i_pwrite)
    begin
      if (i_paddr == ADDR_SYS_CLK)
        sys_clk_q <= i_pwdata[7:0];
      if (i_paddr == ADDR_LF_CLK)
        lf_src_q <= i_pwdata[2:0];
    end
  end

  // short pre-start choice for a tick wake
  always_comb
  begin
    short_d = (sys_clk_q[XOSC_FIELD_HI:XOSC_FIELD_LO] == XOSC_OFF_CODE);
    if (mode_q == MODE_REG_RET)
    begin
      if (sys_clk_q[BYPASS_BIT])
        short_d = 1'b1;
      if (!xosc_at_entry_q)
        short_d = 1'b0;
    end
  end

  // mode sequencing: sleep, pre-start or start-up, then wake
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q         <= ST_ACTIVE;
      mode_q          <= MODE_ACTIVE;
      timers_on_q     <= 1'b0;
      xosc_at_entry_q <= 1'b0;
      short_q         <= 1'b0;
      cnt_q           <= 16'h0000;
      cause_q         <= MASK_NONE;
    end
    else
    begin
      case (state_q)
        ST_ACTIVE:
          if (sleep_wr)
          begin
            state_q         <= ST_SLEEP;
            mode_q          <= i_pwdata[2:0];
            timers_on_q     <= (i_pwdata[2:0] == MODE_MEM_RET_ON) ||
                               ((i_pwdata[2:0] != MODE_MEM_RET_OFF) &&
                                lf_active);
            xosc_at_entry_q <= xosc_run_s;
          end
        ST_SLEEP:
          if (|hit)
          begin
            cause_q <= hit;
            if (hit[SRC_TICK] && !hit[SRC_PIN] && mode_q != MODE_STANDBY)
            begin
              state_q <= ST_PRESTART;
              short_q <= short_d;
              cnt_q   <= short_d ? SHORT_PRESTART_CYC
                                 : P_LONG_PRESTART_CYC;
            end
            else
            begin
              state_q <= ST_STARTUP;
              short_q <= 1'b0;
              cnt_q   <= standby_slp ? STANDBY_WAKE_CYC
                                     : PIN_STARTUP_CYC;
            end
          end
        ST_PRESTART, ST_STARTUP:
          if (cnt_q <= 16'h0001)
            state_q <= ST_WAKE;
          else
            cnt_q <= cnt_q - 16'h0001;
        ST_WAKE:
        begin
          state_q <= ST_ACTIVE;
          mode_q  <= MODE_ACTIVE;
        end
        default:
          state_q <= ST_ACTIVE;
      endcase
    end
  end

  // wake outcome pulses: memory retention resets, the rest resumes
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_sys_reset_req <= 1'b0;
      o_resume        <= 1'b0;
    end
    else
    begin
      o_sys_reset_req <= (state_q == ST_WAKE) &&
                         ((mode_q == MODE_MEM_RET_ON) ||
                          (mode_q == MODE_MEM_RET_OFF));
      o_resume        <= (state_q == ST_WAKE) &&
                         ((mode_q == MODE_REG_RET) ||
                          (mode_q == MODE_STANDBY));
    end
  end

  // power and clock enables; the crystal is forced off in start-up
  // because every wake without a pre-start restarts on the rc oscillator
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_cpu_clk_en          <= 1'b0;
      o_io_active           <= 1'b0;
      o_regulator_en        <= 1'b0;
      o_fast_crystal_osc_en <= 1'b0;
      o_fast_rc_osc_en      <= 1'b0;
      o_slow_osc_en         <= 1'b0;
      o_timers_clk_en       <= 1'b0;
    end
    else
    begin
      o_cpu_clk_en     <= (state_q == ST_ACTIVE);
      o_io_active      <= (state_q != ST_SLEEP) || standby_slp;
      o_regulator_en   <= (state_q != ST_SLEEP) || standby_slp;
      o_fast_rc_osc_en <= (state_q != ST_SLEEP) || standby_slp;
      o_slow_osc_en    <= (state_q == ST_ACTIVE) ? lf_active
                                                 : timers_on_q;
      o_timers_clk_en  <= (state_q == ST_ACTIVE) ? lf_active
                                                 : timers_on_q;
      case (state_q)
        ST_SLEEP:
          o_fast_crystal_osc_en <= standby_slp ||
                                   ((mode_q == MODE_REG_RET) &&
                                    sys_clk_q[BYPASS_BIT]);
        ST_STARTUP:
          o_fast_crystal_osc_en <= 1'b0;
        default:
          o_fast_crystal_osc_en <=
            (sys_clk_q[XOSC_FIELD_HI:XOSC_FIELD_LO] != XOSC_OFF_CODE);
      endcase
    end
  end

  // helper: cycles spent in start-up for the bound check
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      startup_cnt_q <= 16'h0000;
    else if (state_q == ST_STARTUP)
      startup_cnt_q <= startup_cnt_q + 16'h0001;
    else
      startup_cnt_q <= 16'h0000;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_enter_prestart;
    (state_q == ST_SLEEP) ##1 (state_q == ST_PRESTART);
  endsequence

  sequence s_standby_wake;
    standby_slp && (|hit) ##1 (state_q == ST_STARTUP);
  endsequence

  AST_REGRET_CODE: assert property (
    sleep_wr && (i_pwdata[2:0] == MODE_REG_RET) |=>
      (state_q == ST_SLEEP) && (mode_q == MODE_REG_RET) &&
      (timers_on_q == lf_active))
    else $error("code 100 did not enter register retention");

  AST_PIN_ONLY: assert property (
    (state_q == ST_SLEEP) && ((mode_q == MODE_MEM_RET_OFF) ||
     ((mode_q == MODE_REG_RET) && !timers_on_q)) && !wake_s[SRC_PIN]
      |=> (state_q == ST_SLEEP))
    else $error("timers-off retention woke without a pin event");

  AST_TIMERS_KEPT: assert property (
    (state_q == ST_SLEEP) && $past(state_q == ST_SLEEP) &&
    (mode_q == MODE_MEM_RET_ON) |-> o_timers_clk_en && o_slow_osc_en)
    else $error("slow clock or timers stopped in retention timers on");

  AST_TIMERS_SET: assert property (
    timers_on_q && (mode_q == MODE_MEM_RET_ON || mode_q == MODE_REG_RET)
      |-> (en_mask == MASK_TIMERS))
    else $error("timers-on retention has the wrong wakeup set");

  AST_PIN_STARTUP: assert property (
    startup_cnt_q <= 16'(AST_PIN_BOUND))
    else $error("start-up took longer than 100 us");

  AST_PRESTART_ON: assert property (
    s_enter_prestart ##0 !short_q |=> o_regulator_en)
    else $error("regulators not pre-started for tick wake");

  AST_SHORT_START: assert property (
    s_enter_prestart ##0 short_q |-> ##[1:AST_SHORT_BOUND]
      (state_q == ST_WAKE))
    else $error("short pre-start ran too long");

  AST_MEM_RESET: assert property (
    (state_q == ST_WAKE) && (mode_q == MODE_MEM_RET_ON) |=>
      o_sys_reset_req && !o_resume)
    else $error("memory retention wake did not reset");

  AST_REG_RESUME: assert property (
    (state_q == ST_WAKE) && (mode_q == MODE_REG_RET) |=>
      o_resume && !o_sys_reset_req)
    else $error("register retention wake did not resume");

  AST_BYPASS_SHORT: assert property (
    s_enter_prestart ##0 (mode_q == MODE_REG_RET) &&
    sys_clk_q[BYPASS_BIT] && xosc_at_entry_q |-> short_q)
    else $error("bypass kept crystal on but long pre-start used");

  AST_NO_SHORT_COLD: assert property (
    (state_q == ST_PRESTART) && (mode_q == MODE_REG_RET) &&
    !xosc_at_entry_q |-> !short_q)
    else $error("short pre-start used before crystal was running");

  AST_STANDBY_NO_COMP: assert property (
    standby_slp && ((wake_s & ~MASK_PIN & ~MASK_TIMERS) == MASK_NONE) &&
    !wake_s[SRC_PIN] && !wake_s[SRC_TICK] |=> (state_q == ST_SLEEP))
    else $error("comparator woke the device from standby");

  AST_STANDBY_FAST: assert property (
    s_standby_wake |-> ##[1:AST_STANDBY_BOUND] (state_q == ST_WAKE))
    else $error("standby wake slower than about 100 ns");

  AST_GATED: assert property (
    (state_q == ST_SLEEP) && (hit == MASK_NONE) |=> (state_q == ST_SLEEP))
    else $error("disabled wakeup source left the sleep state");

endmodule
`default_nettype wire

// ===== testbench/lpw_wake_source_model.sv
`timescale 1ns/100ps
`default_nettype none
// far side: wakeup event sources and the fast crystal, behavioural
module lpw_wake_source_model
#(
  parameter int P_XTAL_START_CYC = 20
)(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [4:0] i_fire,
  input  wire logic       i_served,
  input  wire logic       i_xtal_en,
  output var  logic [4:0] o_wake,
  output var  logic       o_xtal_running
);
  logic [4:0] wake_q;
  logic [7:0] xtal_cnt_q;

  // a source holds its level until the core has been woken, so a
  // source the mode ignores stays pending rather than vanishing
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      wake_q <= 5'h00;
    else if (i_served)
      wake_q <= 5'h00;
    else
      wake_q <= wake_q | i_fire;
  end

  // crystal needs a start time and stops as soon as it is disabled
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      xtal_cnt_q <= 8'h00;
    else if (!i_xtal_en)
      xtal_cnt_q <= 8'h00;
    else if (xtal_cnt_q != 8'(P_XTAL_START_CYC))
      xtal_cnt_q <= xtal_cnt_q + 8'h01;
  end

  assign o_wake         = wake_q;
  assign o_xtal_running = (xtal_cnt_q == 8'(P_XTAL_START_CYC));
endmodule
`default_nettype wire

// ===== testbench/lpw_power_manager_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module lpw_power_manager_tb
  import lpw_pkg::*;
;
  typedef struct packed {
    logic [2:0] md;
    logic [7:0] sc;
    logic [2:0] lf;
    logic [4:0] ig;
    logic [4:0] wk;
    logic       rs;
    logic       sh;
  } lpw_case_s;

  // mode, clock ctrl, slow source, ignored, waking, reset, short
  localparam lpw_case_s CASES [14] = '{
    '{MODE_MEM_RET_OFF, 8'h00, 3'h7, 5'h06, 5'h01, 1'b1, 1'b0},
    '{MODE_REG_RET,     8'h00, 3'h7, 5'h06, 5'h01, 1'b0, 1'b0},
    '{MODE_MEM_RET_ON,  8'h00, 3'h7, 5'h00, 5'h01, 1'b1, 1'b0},
    '{MODE_MEM_RET_ON,  8'h00, 3'h7, 5'h18, 5'h04, 1'b1, 1'b0},
    '{MODE_MEM_RET_ON,  8'h00, 3'h7, 5'h00, 5'h02, 1'b1, 1'b0},
    '{MODE_MEM_RET_ON,  8'h10, 3'h7, 5'h00, 5'h02, 1'b1, 1'b1},
    '{MODE_REG_RET,     8'h00, 3'h1, 5'h00, 5'h02, 1'b0, 1'b0},
    '{MODE_REG_RET,     8'h80, 3'h1, 5'h00, 5'h02, 1'b0, 1'b1},
    '{MODE_REG_RET,     8'h10, 3'h1, 5'h00, 5'h02, 1'b0, 1'b0},
    '{MODE_REG_RET,     8'h00, 3'h1, 5'h08, 5'h04, 1'b0, 1'b0},
    '{MODE_STANDBY,     8'h00, 3'h1, 5'h04, 5'h02, 1'b0, 1'b0},
    '{MODE_STANDBY,     8'h00, 3'h7, 5'h04, 5'h08, 1'b0, 1'b0},
    '{MODE_STANDBY,     8'h00, 3'h7, 5'h00, 5'h10, 1'b0, 1'b0},
    '{MODE_STANDBY,     8'h00, 3'h7, 5'h00, 5'h02, 1'b0, 1'b0}
  };

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [4:0]  fire = 5'h00;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [4:0]  wake;
  logic        xtal_run;
  logic        o_cpu_clk_en;
  logic        o_io_active;
  logic        o_regulator_en;
  logic        o_fast_crystal_osc_en;
  logic        rc_en;
  logic        o_slow_osc_en;
  logic        o_timers_clk_en;
  logic        o_sys_reset_req;
  logic        o_resume;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch = 0;
  int          checks_done = 0;

  // 25 MHz
  always #20 clk = ~clk;

  lpw_power_manager #(
    .P_LONG_PRESTART_CYC (16'h0008)
  ) i_lpw_power_manager (
    .i_clk                      (clk),
    .i_rst_b                    (rst_b),
    .i_psel                     (psel),
    .i_penable                  (penable),
    .i_pwrite                   (pwrite),
    .i_paddr                    (paddr),
    .i_pwdata                   (pwdata),
    .o_prdata                   (o_prdata),
    .o_pready                   (o_pready),
    .o_pslverr                  (o_pslverr),
    .i_pin_wake                 (wake[0]),
    .i_tick_wake                (wake[1]),
    .i_comp_wake                (wake[2]),
    .i_radio_irq                (wake[3]),
    .i_misc_peripheral_irq      (wake[4]),
    .i_fast_crystal_osc_running (xtal_run),
    .o_cpu_clk_en               (o_cpu_clk_en),
    .o_io_active                (o_io_active),
    .o_regulator_en             (o_regulator_en),
    .o_fast_crystal_osc_en      (o_fast_crystal_osc_en),
    .o_fast_rc_osc_en           (rc_en),
    .o_slow_osc_en              (o_slow_osc_en),
    .o_timers_clk_en            (o_timers_clk_en),
    .o_sys_reset_req            (o_sys_reset_req),
    .o_resume                   (o_resume)
  );

  lpw_wake_source_model i_lpw_wake_source_model (
    .i_clk          (clk),
    .i_rst_b        (rst_b),
    .i_fire         (fire),
    .i_served       (o_sys_reset_req | o_resume),
    .i_xtal_en      (o_fast_crystal_osc_en),
    .o_wake         (wake),
    .o_xtal_running (xtal_run)
  );

  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      complete_run();
    end
    rdat = o_prdata;
    err = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // enter a mode, try ignored sources, then wake and time it
  task automatic sleep_wake(input lpw_case_s c, output int cyc);
    logic [31:0] r;
    logic        e;
    logic        ton;
    logic        xon;
    ton = (c.md == MODE_MEM_RET_ON)
        || (c.md == MODE_REG_RET && c.lf != LF_SRC_NONE);
    // crystal stays up asleep only in standby or in register retention with the bypass bit set
    xon = (c.md == MODE_STANDBY) || (c.md == MODE_REG_RET && c.sc[7]);
    apb(1'b1, ADDR_POWER_DOWN, {29'h0, c.md}, r, e);
    repeat (3) @(negedge clk);
    `CHK(o_cpu_clk_en, 1'b0)
    `CHK(o_io_active, c.md == MODE_STANDBY)
    `CHK(rc_en, c.md == MODE_STANDBY)
    `CHK(o_fast_crystal_osc_en, xon)
    if (c.md != MODE_STANDBY)
    begin
      `CHK(o_timers_clk_en, ton)
      `CHK(o_slow_osc_en, ton)
    end
    @(posedge clk);
    fire <= c.ig;
    @(posedge clk);
    fire <= 5'h00;
    repeat (20) @(negedge clk);
    `CHK(o_cpu_clk_en, 1'b0)
    @(posedge clk);
    fire <= c.wk;
    @(posedge clk);
    fire <= 5'h00;
    @(negedge clk);
    cyc = 1;
    while (o_sys_reset_req !== 1'b1 && o_resume !== 1'b1 && cyc < 4000)
    begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= 4000)
    begin
      n_mismatch++;
      complete_run();
    end
    `CHK(o_sys_reset_req, c.rs)
    `CHK(o_resume, ~c.rs)
    `CHK(o_regulator_en, 1'b1)
    @(negedge clk);
    `CHK(o_resume | o_sys_reset_req, 1'b0)
    `CHK(o_cpu_clk_en, 1'b1)
  endtask

  task automatic run_case(input lpw_case_s c);
    logic [31:0] r;
    logic        e;
    int          cyc;
    apb(1'b1, ADDR_SYS_CLK, {24'h0, c.sc}, r, e);
    apb(1'b1, ADDR_LF_CLK, {29'h0, c.lf}, r, e);
    // give the crystal time to settle before entering the mode
    repeat (40) @(posedge clk);
    sleep_wake(c, cyc);
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    `CHK(r[8], c.sh)
    `CHK(r[7:3] & c.wk, c.wk)
    if (c.md == MODE_STANDBY)
      `CHK(cyc <= 10, 1'b1)
    if (c.wk == 5'h01)
      `CHK(cyc <= 2512, 1'b1)
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(o_cpu_clk_en, 1'b1)
    apb(1'b0, ADDR_LF_CLK, 32'h0, rd, er);
    `CHK(rd, 32'h0000_000F)
    apb(1'b1, ADDR_SYS_CLK, 32'h0000_00A5, rd, er);
    apb(1'b0, ADDR_SYS_CLK, 32'h0, rd, er);
    `CHK(rd, 32'h0000_00A5)
    apb(1'b0, 8'h10, 32'h0, rd, er);
    `CHK(er, 1'b1)
    apb(1'b1, ADDR_POWER_DOWN, 32'h0000_0001, rd, er);
    apb(1'b0, ADDR_POWER_DOWN, 32'h0, rd, er);
    `CHK(rd, 32'h0000_0000)
    for (int i = 0; i < 14; i++)
      run_case(CASES[i]);
    complete_run();
  end
endmodule
`default_nettype wire
